// ---- hw/agu_consts.svh ----
// constants of the address generation modifier block
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

// ----------------------------------------------------------------
// register map, byte offsets of bank bases
// ----------------------------------------------------------------
`define AGU_PTR_BASE   7'h00
`define AGU_OFS_BASE   7'h20
`define AGU_MDF_BASE   7'h40
`define AGU_BANK_SPAN  7'h20
`define AGU_REG_COUNT  5'd24

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AGU_MDF_RESET  16'hffff
`define AGU_PTR_RESET  16'h0000
`define AGU_OFS_RESET  16'h0000

// ----------------------------------------------------------------
// modifier encodings
// ----------------------------------------------------------------
`define AGU_MDF_LINEAR 16'hffff
`define AGU_MDF_REV    16'h0000
`define AGU_MDF_MODMAX 16'h7fff

// ----------------------------------------------------------------
// bus answer
// ----------------------------------------------------------------
`define AGU_HRESP_OKAY 1'b0

`endif

// ---- hw/agu_pkg.sv ----
// types of the address generation modifier block
package agu_pkg;

  // ----------------------------------------------------------------
  // operand addressing modes presented by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AGU_MD_DATA_CTRL,
    AGU_MD_ADDR_REG,
    AGU_MD_NO_UPDATE,
    AGU_MD_POST_INC1,
    AGU_MD_POST_DEC1,
    AGU_MD_POST_INCN,
    AGU_MD_POST_DECN,
    AGU_MD_INDEXED,
    AGU_MD_PRE_DEC1,
    AGU_MD_DISPL,
    AGU_MD_PC_REL,
    AGU_MD_SPECIAL
  } agu_mode_t;

  // ----------------------------------------------------------------
  // mode groups and arithmetic types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AGU_GRP_REG_DIRECT,
    AGU_GRP_PTR_INDIRECT,
    AGU_GRP_PC_REL,
    AGU_GRP_SPECIAL
  } agu_group_t;

  typedef enum logic [1:0] {
    AGU_AR_LINEAR,
    AGU_AR_MODULO,
    AGU_AR_REVERSE
  } agu_arith_t;

endpackage : agu_pkg

// ---- hw/agu_modifier_regs.sv ----
// modifier, offset and pointer register file with mode classification
`include "agu_consts.svh"

// Behaviour
// - eight 16-bit modifiers choose update arithmetic
// - modifiers also hold plain 16-bit data
// - linear, modulo, reverse-carry for updating and offset indirect modes
// - modulo modulus comes from same modifier
// - reset loads all ones, meaning linear
// - each pointer has its own offset register
// - each pointer has its own modifier register
// - modes classed direct, indirect, relative, special
// - modifier used only by updating and offset indirect modes
// - direct operands in data, address, control registers
// - data-move field picks data or control operand
// - effective-address field picks one of 24 registers
// - pointer updated only by its own triplet
// - own modifier sets update arithmetic in updating and offset modes, other modes linear
// - all 24 registers reachable over the data bus
module agu_modifier_regs #(
  parameter int NUM_TRIPLETS = 8,
  parameter int DATA_W       = 16
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic      [31:0]         hrdata,
  output logic                     hresp,
  // decoder request
  input  wire logic                dec_valid,
  input  wire agu_pkg::agu_mode_t  dec_mode,
  input  wire logic [2:0]          dec_idx,
  input  wire logic [4:0]          dec_ea,
  input  wire logic [5:0]          dec_dm,
  // pointer write-back from the address arithmetic
  input  wire logic                upd_valid,
  input  wire logic [2:0]          upd_idx,
  input  wire logic [DATA_W-1:0]   upd_value,
  // classification and triplet answer
  output logic                     out_valid,
  output agu_pkg::agu_group_t      out_group,
  output logic                     use_modifier,
  output agu_pkg::agu_arith_t      arith_type,
  output logic      [DATA_W-1:0]   modulus,
  output logic      [DATA_W-1:0]   sel_pointer,
  output logic      [DATA_W-1:0]   sel_offset,
  output logic      [DATA_W-1:0]   sel_modifier,
  output logic      [DATA_W-1:0]   direct_operand,
  output logic                     reg_ref,
  output logic                     ctrl_ref,
  output logic      [1:0]          dreg_count,
  output logic      [3:0]          dreg_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef logic [NUM_TRIPLETS-1:0][DATA_W-1:0] agu_bank_t;

  typedef struct packed {
    agu_bank_t           ptr;        // pointer registers
    agu_bank_t           ofs;        // offset registers
    // modifier registers
    agu_bank_t           mdf;
    logic                dphase;     // bus data phase pending
    logic                wr;         // pending transfer is a write
    logic                hit;        // pending address is mapped
    logic [4:0]          widx;       // pending register index
    logic [31:0]         rdata;      // read data for the bus
    logic                ovalid;     // answer strobe
    agu_pkg::agu_group_t grp;        // mode group
    logic                usem;       // modifier consulted
    agu_pkg::agu_arith_t arith;      // update arithmetic
    logic [DATA_W-1:0]   modv;       // buffer modulus
    logic [DATA_W-1:0]   sptr;       // triplet pointer
    logic [DATA_W-1:0]   sofs;       // triplet offset
    logic [DATA_W-1:0]   smdf;       // triplet modifier
    logic [DATA_W-1:0]   dop;        // direct operand
    logic                rref;       // register reference
    logic                cref;       // control register reference
    logic [1:0]          dcnt;       // data register count
    logic [3:0]          dsel;       // first data register
  } agu_state_t;

  agu_state_t s_reg;                  // registered state
  agu_state_t s_next;                 // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // read one of the 24 registers by bank and triplet index
  function automatic logic [DATA_W-1:0] reg_pick(
    input agu_bank_t  p,
    input agu_bank_t  o,
    input agu_bank_t  m,
    input logic [4:0] i
  );
    logic [DATA_W-1:0] v;
    // bank 3 reads as zero
    v = '0;
    case (i[4:3])
      2'd0:    v = p[i[2:0]];
      2'd1:    v = o[i[2:0]];
      2'd2:    v = m[i[2:0]];
      default: v = '0;
    endcase
    return v;
  endfunction : reg_pick

  // map a byte address to a register index, bank in upper bits
  function automatic logic [5:0] addr_idx(input logic [31:0] a);
    logic [6:0] lo;
    logic [5:0] r;
    lo = a[6:0];
    // 6'h20 flags an unmapped address
    r  = 6'h20;
    if (a[31:7] == 25'h0 && a[1:0] == 2'b00) begin
      if (lo >= `AGU_PTR_BASE && lo < `AGU_PTR_BASE + `AGU_BANK_SPAN)
        r = {3'b000, 3'(lo[4:2])};
      else if (lo >= `AGU_OFS_BASE &&
               lo < `AGU_OFS_BASE + `AGU_BANK_SPAN)
        r = {3'b001, 3'(lo[4:2])};
      else if (lo >= `AGU_MDF_BASE &&
               lo < `AGU_MDF_BASE + `AGU_BANK_SPAN)
        r = {3'b010, 3'(lo[4:2])};
    end
    return r;
  endfunction : addr_idx

  // decode a modifier word into its arithmetic type
  function automatic agu_pkg::agu_arith_t mdf_type(
    input logic [DATA_W-1:0] m
  );
    agu_pkg::agu_arith_t t;
    t = agu_pkg::AGU_AR_LINEAR;
    // zero reverse, low half modulo
    if (m == `AGU_MDF_REV)
      t = agu_pkg::AGU_AR_REVERSE;
    else if (m <= `AGU_MDF_MODMAX)
      t = agu_pkg::AGU_AR_MODULO;
    else
      t = agu_pkg::AGU_AR_LINEAR;
    return t;
  endfunction : mdf_type

  // group each addressing mode
  function automatic agu_pkg::agu_group_t mode_group(
    input agu_pkg::agu_mode_t md
  );
    agu_pkg::agu_group_t g;
    // spare codes are pointer indirect
    g = agu_pkg::AGU_GRP_SPECIAL;
    case (md)
      agu_pkg::AGU_MD_DATA_CTRL,
      agu_pkg::AGU_MD_ADDR_REG: g = agu_pkg::AGU_GRP_REG_DIRECT;
      agu_pkg::AGU_MD_PC_REL:   g = agu_pkg::AGU_GRP_PC_REL;
      agu_pkg::AGU_MD_SPECIAL:  g = agu_pkg::AGU_GRP_SPECIAL;
      default:                  g = agu_pkg::AGU_GRP_PTR_INDIRECT;
    endcase
    return g;
  endfunction : mode_group

  // modes that update or offset a pointer consult its modifier
  function automatic logic mode_uses_mdf(
    input agu_pkg::agu_mode_t md
  );
    logic u;
    // updating and offset modes only
    u = 1'b0;
    case (md)
      agu_pkg::AGU_MD_POST_INC1,
      agu_pkg::AGU_MD_POST_DEC1,
      agu_pkg::AGU_MD_POST_INCN,
      agu_pkg::AGU_MD_POST_DECN,
      agu_pkg::AGU_MD_INDEXED,
      agu_pkg::AGU_MD_PRE_DEC1,
      agu_pkg::AGU_MD_DISPL:   u = 1'b1;
      default:                 u = 1'b0;
    endcase
    return u;
  endfunction : mode_uses_mdf

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // bus, write-back and decoder requests in one pass
  always_comb begin
    logic [5:0] ai;
    logic [2:0] ti;
    s_next        = s_reg;
    ai            = addr_idx(haddr);
    ti            = dec_idx;
    s_next.ovalid = 1'b0;

    // pointer write-back touches only the named pointer
    if (upd_valid) begin
      // a bus write below wins
      s_next.ptr[upd_idx] = upd_value;
    end

    // bus write completes in its data phase, after write-back
    // upper write half is dropped
    if (s_reg.dphase && s_reg.wr && s_reg.hit) begin
      case (s_reg.widx[4:3])
        2'd0:    s_next.ptr[s_reg.widx[2:0]] = hwdata[DATA_W-1:0];
        2'd1:    s_next.ofs[s_reg.widx[2:0]] = hwdata[DATA_W-1:0];
        2'd2:    s_next.mdf[s_reg.widx[2:0]] = hwdata[DATA_W-1:0];
        default: s_next.ptr = s_next.ptr;
      endcase
    end

    // data phase ends in this cycle
    s_next.dphase = 1'b0;

    // new address phase
    // taken only while hready is high
    if (hsel && hready && htrans[1]) begin
      s_next.dphase = 1'b1;
      s_next.wr     = hwrite;
      s_next.hit    = ~ai[5];
      s_next.widx   = ai[4:0];
      s_next.rdata  = 32'h0000_0000;
      if (!hwrite && !ai[5]) begin
        // reads see any write landing in this same cycle
        s_next.rdata[DATA_W-1:0] =
          reg_pick(s_next.ptr, s_next.ofs, s_next.mdf,
                   ai[4:0]);
      end
    end

    // decoder request, answered one cycle later
    if (dec_valid) begin
      // answers use pre-edge values
      s_next.ovalid = 1'b1;
      s_next.grp    = mode_group(dec_mode);
      s_next.usem   = mode_uses_mdf(dec_mode);
      // triplet fields come from the same index only
      s_next.sptr   = s_reg.ptr[ti];
      s_next.sofs   = s_reg.ofs[ti];
      s_next.smdf   = s_reg.mdf[ti];
      // own modifier picks arithmetic, otherwise linear
      if (mode_uses_mdf(dec_mode)) begin
        s_next.arith = mdf_type(s_reg.mdf[ti]);
      end else begin
        s_next.arith = agu_pkg::AGU_AR_LINEAR;
      end
      // modulus is the modifier plus one for modulo arithmetic
      if (mode_uses_mdf(dec_mode) &&
          mdf_type(s_reg.mdf[ti]) == agu_pkg::AGU_AR_MODULO) begin
        s_next.modv = s_reg.mdf[ti] + 16'h0001;
      end else begin
        s_next.modv = 16'h0000;
      end
      // register direct operand selection
      s_next.rref = 1'b0;
      s_next.cref = 1'b0;
      s_next.dop  = 16'h0000;
      s_next.dcnt = 2'd0;
      s_next.dsel = 4'h0;
      case (dec_mode)
        agu_pkg::AGU_MD_DATA_CTRL: begin
          // fields of the data-move word
          s_next.rref = 1'b1;
          s_next.dcnt = dec_dm[5:4];
          s_next.dsel = dec_dm[3:0];
        end
        agu_pkg::AGU_MD_ADDR_REG: begin
          // ea names one of 24 registers
          s_next.rref = 1'b1;
          s_next.dop  = reg_pick(s_reg.ptr, s_reg.ofs, s_reg.mdf,
                                 dec_ea);
        end
        agu_pkg::AGU_MD_SPECIAL: begin
          // special instructions name a control register
          s_next.cref = 1'b1;
          s_next.rref = 1'b1;
          s_next.dsel = dec_dm[3:0];
        end
        default: begin
          // memory, not register, reference
          s_next.rref = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // modifiers reset to all ones so pointers start linear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // the rest clears to zero
      s_reg        <= '0;
      s_reg.mdf    <= {NUM_TRIPLETS{`AGU_MDF_RESET}};
      s_reg.ptr    <= {NUM_TRIPLETS{`AGU_PTR_RESET}};
      s_reg.ofs    <= {NUM_TRIPLETS{`AGU_OFS_RESET}};
      s_reg.grp    <= agu_pkg::AGU_GRP_REG_DIRECT;
      s_reg.arith  <= agu_pkg::AGU_AR_LINEAR;
    end else if (ce) begin
      // low enable holds all state
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // answers come from flip-flops
  // hreadyout falls only when frozen
  // the data phase stretches while the clock enable is low
  assign hreadyout      = ~s_reg.dphase | ce;
  assign hrdata         = s_reg.rdata;
  assign hresp          = `AGU_HRESP_OKAY;
  assign out_valid      = s_reg.ovalid;
  assign out_group      = s_reg.grp;
  assign use_modifier   = s_reg.usem;
  assign arith_type     = s_reg.arith;
  assign modulus        = s_reg.modv;
  assign sel_pointer    = s_reg.sptr;
  assign sel_offset     = s_reg.sofs;
  assign sel_modifier   = s_reg.smdf;
  assign direct_operand = s_reg.dop;
  assign reg_ref        = s_reg.rref;
  assign ctrl_ref       = s_reg.cref;
  assign dreg_count     = s_reg.dcnt;
  assign dreg_sel       = s_reg.dsel;

  // hsize is accepted but only whole-word transfers are expected
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule : agu_modifier_regs

// ---- sim/agu_modifier_regs_properties.sv ----
// concurrent checks on the ports of the modifier register file
module agu_modifier_regs_checker #(
  parameter int DATA_W = 16
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                ce,
  input wire logic                hsel,
  input wire logic                hready,
  input wire logic [1:0]          htrans,
  input wire logic                hreadyout,
  input wire logic                dec_valid,
  input wire agu_pkg::agu_mode_t  dec_mode,
  input wire logic [5:0]          dec_dm,
  input wire logic                out_valid,
  input wire agu_pkg::agu_group_t out_group,
  input wire logic                use_modifier,
  input wire agu_pkg::agu_arith_t arith_type,
  input wire logic [DATA_W-1:0]   modulus,
  input wire logic [DATA_W-1:0]   sel_modifier,
  input wire logic                reg_ref,
  input wire logic                ctrl_ref,
  input wire logic [1:0]          dreg_count,
  input wire logic [3:0]          dreg_sel
);
  // ----------------------------------------------------------------
  // helpers: request taken, data-move fields
  // ----------------------------------------------------------------
  logic       taken;
  logic [3:0] dm_sel;
  logic [1:0] dm_cnt;
  assign taken  = ce && dec_valid;
  assign dm_sel = dec_dm[3:0];
  assign dm_cnt = dec_dm[5:4];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_answer_pulse: assert property (taken |=> out_valid)
    else $error("no answer after request");
  a_no_stray: assert property (ce && !dec_valid |=> !out_valid)
    else $error("answer without request");
  a_direct_class: assert property (
    taken && dec_mode inside {agu_pkg::AGU_MD_DATA_CTRL,
      agu_pkg::AGU_MD_ADDR_REG} |=> out_group == agu_pkg::AGU_GRP_REG_DIRECT
      && reg_ref && !ctrl_ref && !use_modifier)
    else $error("direct mode misclassed");
  a_update_mdf: assert property (
    taken && dec_mode inside {[agu_pkg::AGU_MD_POST_INC1:
      agu_pkg::AGU_MD_DISPL]} |=> use_modifier
      && out_group == agu_pkg::AGU_GRP_PTR_INDIRECT)
    else $error("updating mode ignores modifier");
  a_no_update: assert property (
    taken && dec_mode == agu_pkg::AGU_MD_NO_UPDATE |=> !use_modifier
      && out_group == agu_pkg::AGU_GRP_PTR_INDIRECT && modulus == '0)
    else $error("no-update mode uses modifier");
  a_pc_linear: assert property (
    taken && dec_mode == agu_pkg::AGU_MD_PC_REL |=> !use_modifier
      && out_group == agu_pkg::AGU_GRP_PC_REL
      && arith_type == agu_pkg::AGU_AR_LINEAR)
    else $error("relative mode not linear");
  a_special_ctrl: assert property (
    taken && dec_mode == agu_pkg::AGU_MD_SPECIAL |=> ctrl_ref && reg_ref
      && out_group == agu_pkg::AGU_GRP_SPECIAL && dreg_sel == $past(dm_sel))
    else $error("special mode wrong");
  a_dm_fields: assert property (
    taken && dec_mode == agu_pkg::AGU_MD_DATA_CTRL |=>
      dreg_count == $past(dm_cnt) && dreg_sel == $past(dm_sel))
    else $error("data-move fields wrong");
  a_arith_decode: assert property (out_valid && use_modifier |->
    arith_type == (sel_modifier == '0 ? agu_pkg::AGU_AR_REVERSE :
      sel_modifier[DATA_W-1] ? agu_pkg::AGU_AR_LINEAR :
      agu_pkg::AGU_AR_MODULO))
    else $error("arithmetic not from modifier");
  a_modulus_src: assert property (out_valid &&
    arith_type == agu_pkg::AGU_AR_MODULO |-> modulus == sel_modifier + 1'b1)
    else $error("modulus not from modifier");
  a_bus_no_wait: assert property (
    ce && hsel && hready && htrans[1] ##1 ce |-> hreadyout)
    else $error("bus wait state with clock enabled");
  a_bus_stall: assert property (
    $past(ce && hsel && hready && htrans[1]) && !ce |-> !hreadyout)
    else $error("data phase not held while frozen");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_modulo: cover property (out_valid && arith_type == agu_pkg::AGU_AR_MODULO);
  c_reverse: cover property (out_valid &&
    arith_type == agu_pkg::AGU_AR_REVERSE);
  c_pc_rel: cover property (out_valid && out_group == agu_pkg::AGU_GRP_PC_REL);
endmodule : agu_modifier_regs_checker

// ---- sim/agu_dec_model.sv ----
// decoder and address arithmetic stand-in driving the request side
module agu_dec_model (
  input  wire logic          hclk,
  output logic               dec_valid,
  output agu_pkg::agu_mode_t dec_mode,
  output logic [2:0]         dec_idx,
  output logic [4:0]         dec_ea,
  output logic [5:0]         dec_dm,
  output logic               upd_valid,
  output logic [2:0]         upd_idx,
  output logic [15:0]        upd_value
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet request lines at time zero
  initial begin
    dec_valid = 1'h0;
    dec_mode  = agu_pkg::AGU_MD_NO_UPDATE;
    dec_idx   = 3'h0;
    dec_ea    = 5'h0;
    dec_dm    = 6'h0;
    upd_valid = 1'h0;
    upd_idx   = 3'h0;
    upd_value = 16'h0;
  end
  // one-cycle request; released fields flip so stale values never match
  task automatic request(input agu_pkg::agu_mode_t m, input logic [2:0] i,
                         input logic [4:0] ea, input logic [5:0] dm);
    @(posedge hclk);
    dec_valid <= 1'h1;
    dec_mode  <= m;
    dec_idx   <= i;
    dec_ea    <= ea;
    dec_dm    <= dm;
    @(posedge hclk);
    dec_valid <= 1'h0;
    dec_mode  <= agu_pkg::agu_mode_t'(~m);
    dec_idx   <= ~i;
    dec_ea    <= ~ea;
    dec_dm    <= ~dm;
  endtask : request
  // one-cycle pointer write-back from the address arithmetic
  task automatic write_back(input logic [2:0] i, input logic [15:0] v);
    @(posedge hclk);
    upd_valid <= 1'h1;
    upd_idx   <= i;
    upd_value <= v;
    @(posedge hclk);
    upd_valid <= 1'h0;
    upd_idx   <= ~i;
    upd_value <= ~v;
  endtask : write_back
endmodule : agu_dec_model

// ---- sim/agu_modifier_and_mode_select_tb.sv ----
// self-checking bench for the modifier register file
module agu_modifier_and_mode_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                hclk = 1'h0;
  logic                hresetn = 1'h0;
  logic                ce = 1'h1;
  logic                hsel = 1'h0;
  logic                hwrite = 1'h0;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         haddr = 32'h0;
  logic [31:0]         hwdata = 32'h0;
  logic [31:0]         hrdata;
  logic                hreadyout, hresp, dec_valid, upd_valid, out_valid;
  logic                use_modifier, reg_ref, ctrl_ref;
  logic [2:0]          dec_idx, upd_idx;
  logic [4:0]          dec_ea;
  logic [5:0]          dec_dm;
  logic [1:0]          dreg_count;
  logic [3:0]          dreg_sel;
  logic [15:0]         upd_value, modulus, sel_pointer, sel_offset;
  logic [15:0]         sel_modifier, direct_operand;
  agu_pkg::agu_mode_t  dec_mode;
  agu_pkg::agu_group_t out_group;
  agu_pkg::agu_arith_t arith_type;
  logic [15:0]         shadow [24];
  int                  bad_count = 0;
  int                  comparisons = 0;
  // 200 MHz core clock
  always #2.5 hclk = ~hclk;
  agu_dec_model i_dec (.hclk(hclk), .dec_valid(dec_valid),
    .dec_mode(dec_mode), .dec_idx(dec_idx), .dec_ea(dec_ea), .dec_dm(dec_dm),
    .upd_valid(upd_valid), .upd_idx(upd_idx), .upd_value(upd_value));
  agu_modifier_regs i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .dec_valid(dec_valid), .dec_mode(dec_mode), .dec_idx(dec_idx),
    .dec_ea(dec_ea), .dec_dm(dec_dm), .upd_valid(upd_valid),
    .upd_idx(upd_idx), .upd_value(upd_value), .out_valid(out_valid),
    .out_group(out_group), .use_modifier(use_modifier),
    .arith_type(arith_type), .modulus(modulus), .sel_pointer(sel_pointer),
    .sel_offset(sel_offset), .sel_modifier(sel_modifier),
    .direct_operand(direct_operand), .reg_ref(reg_ref), .ctrl_ref(ctrl_ref),
    .dreg_count(dreg_count), .dreg_sel(dreg_sel));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ready and read data are both taken at a rising edge
  task automatic wait_ready(output logic [31:0] rd);
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    rd = hrdata;
    if (hreadyout !== 1'h1) begin
      bad_count++;
      $display("Error %0t: bus never ready", $time);
      tally_and_finish();
    end
  endtask : wait_ready
  // single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {25'h0, a};
    wait_ready(rd);
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(rd);
  endtask : bus
  // write with junk in the unused upper half
  task automatic put(input int r, input logic [15:0] v);
    logic [31:0] rd;
    bus(1'h1, 7'(r * 4), {16'hbeef, v}, rd);
    shadow[r] = v;
  endtask : put
  task automatic get(input int r, output logic [31:0] rd);
    bus(1'h0, 7'(r * 4), 32'h0, rd);
  endtask : get
  task automatic ask(input agu_pkg::agu_mode_t m, input logic [2:0] i,
                     input logic [4:0] ea, input logic [5:0] dm);
    i_dec.request(m, i, ea, dm);
    @(negedge hclk);
    check(out_valid, 1'h1);
  endtask : ask
  function automatic logic [1:0] ar(input logic [15:0] m);
    return (m == 16'h0) ? 2'h2 : (m[15] ? 2'h0 : 2'h1);
  endfunction : ar
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    for (int r = 0; r < 24; r++) begin
      get(r, rd);
      check(rd, (r < 16) ? 32'h0 : 32'hffff);
    end
  endtask : t_reset
  task automatic t_storage();
    logic [31:0] rd;
    for (int r = 0; r < 24; r++) begin
      put(r, 16'ha5c3 ^ 16'(r * 1057));
      get(r, rd);
      check(rd, {16'h0, shadow[r]});
    end
    bus(1'h1, 7'h60, 32'h1234, rd);
    bus(1'h0, 7'h60, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 1'h0);
  endtask : t_storage
  // each updating and offset mode in turn, across all three arithmetic kinds
  task automatic t_arith();
    logic [15:0] mdf [8] = '{16'h0, 16'h1, 16'h7fff, 16'h8000,
                             16'hffff, 16'h7, 16'h1234, 16'hc000};
    for (int n = 0; n < 8; n++) begin
      put(16 + n, mdf[n]);
      ask(agu_pkg::agu_mode_t'(3 + n % 7), 3'(n), 5'h0, 6'h0);
      check(sel_modifier, mdf[n]);
      check(sel_pointer, shadow[n]);
      check(sel_offset, shadow[8 + n]);
      check(arith_type, ar(mdf[n]));
      check(modulus, ar(mdf[n]) == 2'h1 ? mdf[n] + 16'h1 : 16'h0);
    end
  endtask : t_arith
  // modifier of triplet 2 is modulo here, so linear answers stand out
  task automatic t_modes();
    for (int m = 0; m < 12; m++) begin
      ask(agu_pkg::agu_mode_t'(m), 3'h2, 5'h12, 6'h25);
      check(out_group, (m < 2) ? 0 : (m < 10) ? 1 : m - 8);
      check(use_modifier, m > 2 && m < 10);
      check(reg_ref, m < 2 || m == 11);
      check(ctrl_ref, m == 11);
      if (m >= 10) check(arith_type, 0);
      if (m > 2 && m < 10) check(arith_type, 1);
      if (m == 0 || m == 11) check(dreg_sel, 5);
      if (m == 0) check(dreg_count, 2);
      if (m == 1) check(direct_operand, shadow[18]);
    end
  endtask : t_modes
  task automatic t_direct();
    for (int ea = 0; ea < 24; ea++) begin
      ask(agu_pkg::AGU_MD_ADDR_REG, 3'h0, 5'(ea), 6'h0);
      check(direct_operand, shadow[ea]);
    end
  endtask : t_direct
  task automatic t_writeback();
    logic [31:0] rd;
    i_dec.write_back(3'h3, 16'h4321);
    get(3, rd);
    check(rd, 32'h4321);
    get(4, rd);
    check(rd, {16'h0, shadow[4]});
    ask(agu_pkg::AGU_MD_POST_DEC1, 3'h3, 5'h0, 6'h0);
    check(sel_pointer, 32'h4321);
  endtask : t_writeback
  // a low clock enable stretches the data phase and drops requests
  task automatic t_freeze();
    fork
      put(19, 16'h0003);
      begin
        repeat (2) @(posedge hclk);
        ce <= 1'h0;
        @(posedge hclk);
        ce <= 1'h1;
      end
    join
    ce <= 1'h0;
    i_dec.request(agu_pkg::AGU_MD_POST_INC1, 3'h3, 5'h0, 6'h0);
    @(negedge hclk);
    check(out_valid, 1'h0);
    @(posedge hclk);
    ce <= 1'h1;
    ask(agu_pkg::AGU_MD_POST_INC1, 3'h3, 5'h0, 6'h0);
    check(modulus, 16'h4);
  endtask : t_freeze
  // reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_storage();
    t_arith();
    t_modes();
    t_direct();
    t_writeback();
    t_freeze();
    tally_and_finish();
  end
endmodule : agu_modifier_and_mode_select_tb
bind agu_modifier_regs agu_modifier_regs_checker #(.DATA_W(DATA_W)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .hready(hready),
  .htrans(htrans), .hreadyout(hreadyout), .dec_valid(dec_valid),
  .dec_mode(dec_mode), .dec_dm(dec_dm), .out_valid(out_valid),
  .out_group(out_group), .use_modifier(use_modifier),
  .arith_type(arith_type), .modulus(modulus), .sel_modifier(sel_modifier),
  .reg_ref(reg_ref), .ctrl_ref(ctrl_ref), .dreg_count(dreg_count),
  .dreg_sel(dreg_sel));
